/* rtl/acs_cfg.svh */
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// =====================================================================
// register offsets
`define ACS_OFS_LINE_PARALLEL_BRIDGE_MODE     8'h00
`define ACS_OFS_DIAG          8'h01
`define ACS_OFS_CLOCK         8'h02
`define ACS_OFS_SAP           8'h03
`define ACS_OFS_CHAN_STATE    8'h04
`define ACS_OFS_FAULT         8'h05
`define ACS_OFS_LINE_DETECT   8'h06
`define ACS_OFS_MISC3         8'h21
`define ACS_OFS_ILIM          8'h25
`define ACS_OFS_MISC4         8'h26

// =====================================================================
// reset values
`define ACS_RST_LINE_PARALLEL_BRIDGE_MODE     8'h00
`define ACS_RST_DIAG          8'h00
`define ACS_RST_CLOCK         8'h13
`define ACS_RST_SAP           8'h03
`define ACS_RST_CHAN_STATE    8'hFF
`define ACS_RST_MISC3         8'h00
`define ACS_RST_MISC4         8'h40

// =====================================================================
// field positions
`define ACS_BIT_CLEAR_FAULT   7
`define ACS_BIT_PARALLEL_BRIDGE_MODE_FLIP     6
`define ACS_BIT_ILIM_MASK     5
`define ACS_MISC3_STORE       8'h78
`define ACS_BIT_PARALLEL_BRIDGE_MODE_REQ12    4
`define ACS_BIT_PARALLEL_BRIDGE_MODE_REQ34    5

// =====================================================================
// channel state, switching ratio, word length, rate codes
`define ACS_STATE_STANDBY     2'h3
`define ACS_SW_RATIO_0        6'd8
`define ACS_SW_RATIO_1        6'd10
`define ACS_SW_RATIO_2        6'd38
`define ACS_SW_RATIO_3        6'd44
`define ACS_SW_RATIO_4        6'd48
`define ACS_WORD_0            6'd16
`define ACS_WORD_1            6'd18
`define ACS_WORD_2            6'd20
`define ACS_WORD_3            6'd24
`define ACS_WORD_4            6'd32
`define ACS_RATE_44K1         2'h0
`define ACS_RATE_48K          2'h1
`define ACS_RATE_96K          2'h2

// =====================================================================
// line diagnostic window in ohms, bus address
`define ACS_LINE_OHMS_MIN     13'd600
`define ACS_LINE_OHMS_MAX     13'd4700
`define ACS_ADDR_UPPER        5'h1A

`endif

/* rtl/acs_pkg.sv */
package acs_pkg;

   typedef enum logic [1:0] {
      ACS_FMT_I2S,
      ACS_FMT_RJ,
      ACS_FMT_LJ,
      ACS_FMT_TDM
   } acs_fmt_t;

   typedef struct packed {
      acs_fmt_t   format;
      logic [5:0] word_bits;
      logic [1:0] rate;
      logic [2:0] tdm_cfg;
   } acs_sap_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } acs_wr_t;

   typedef enum logic [3:0] {
      ACS_ST_IDLE,
      ACS_ST_ADDR,
      ACS_ST_ACK_ADDR,
      ACS_ST_PTR,
      ACS_ST_ACK_WR,
      ACS_ST_WDATA,
      ACS_ST_RDATA,
      ACS_ST_RACK
   } acs_link_state_t;

endpackage

/* rtl/acs_sync.sv */
`timescale 1ns/1ps

module acs_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_sys_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;

   // =====================================================================
   // two-stage synchroniser
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta_reg <= RESET_VAL;
         sync_o   <= RESET_VAL;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end

endmodule

/* rtl/acs_regs.sv */
`timescale 1ns/1ps
`include "acs_cfg.svh"

// What this block does
// - status bits 3..0 flag per-channel current limiting; bits 7..4 read zero
// - high-pass control register at 0x26 resets to 0x40
// - low three bits pick the high-pass corner, 3.7 Hz up to 463 Hz
// - switching ratios 38, 44 and 48 times sample rate are offered
// - switching ratios 8 and 10 times sample rate are offered
// - paired bridge channels with differing states raise a fault
// - parallel-bridge change takes effect only while all channels stand by
// - load diagnostics run on parallel-bridge channels too
// - line-driver mode per channel is chosen in register 0x00
// - line diagnostic detects an amplifier of 600 ohm to 4.7 kohm
// - block is a bus target only; never drives clock or starts transfers
// - bus clock up to 400 kHz is accepted
// - audio port accepts I2S, right-justified, left-justified and TDM
// - audio word lengths 16, 18, 20, 24 and 32 bits
// - audio sample rates 96, 48 and 44.1 kHz
// - audio port bits 3..5 act only in TDM format
// - 0x21 bit 5 set hides current-limit events from the warning pin
module acs_regs
   import acs_pkg::*;
(
   input  wire logic         clk_sys_i,
   input  wire logic         reset_i,
   input  wire logic         scl_i,
   input  wire logic         sda_i,
   output logic              sda_o,
   output logic              sda_oe_o,
   input  wire logic [1:0]   addr_sel_i,
   input  wire logic [3:0]   current_limit_i,
   input  wire logic         diag_valid_i,
   input  wire logic [1:0]   diag_chan_i,
   input  wire logic [12:0]  diag_ohms_i,
   output logic              warn_n_o,
   output logic [2:0]        highpass_corner_select_o,
   output logic [5:0]        sw_ratio_o,
   output acs_sap_cfg_t      sap_cfg_o,
   output logic [7:0]        chan_state_o,
   output logic [3:0]        line_driver_o,
   output logic [1:0]        parallel_bridge_mode_o,
   output logic              parallel_bridge_mode_flip_o,
   output logic [3:0]        diag_run_o
);

   logic [1:0]      link_s;
   logic [1:0]      addr_sel_s;
   logic            scl_s;
   logic            sda_s;
   logic            scl_d_reg;
   logic            sda_d_reg;
   logic            scl_rise;
   logic            scl_fall;
   logic            start_det;
   logic            stop_det;
   acs_link_state_t state_reg;
   logic [3:0]      bit_cnt_reg;
   logic [7:0]      shift_reg;
   logic [7:0]      ptr_reg;
   logic            rd_mode_reg;
   logic            acked_reg;
   logic            wr_stb_reg;
   acs_wr_t         wr_reg;
   logic [7:0]      rd_data;
   logic [7:0]      line_parallel_bridge_mode_reg;
   logic [7:0]      diag_reg;
   logic [7:0]      clock_reg;
   logic [7:0]      sap_reg;
   logic [7:0]      chan_state_reg;
   logic [7:0]      misc3_reg;
   logic [7:0]      misc4_reg;
   logic            clear_fault_reg;
   logic [3:0]      ilim_flags_reg;
   logic [1:0]      parallel_bridge_mode_fault_reg;
   logic [3:0]      line_detect_reg;
   logic            all_standby;

   // =====================================================================
   // pin synchronisers
   acs_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_link_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   ({scl_i, sda_i}),
      .sync_o    (link_s)
   );

   acs_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_addr_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (addr_sel_i),
      .sync_o    (addr_sel_s)
   );

   assign scl_s     = link_s[1];
   assign sda_s     = link_s[0];
   assign scl_rise  = scl_s & ~scl_d_reg;
   assign scl_fall  = ~scl_s & scl_d_reg;
   assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign sda_o     = 1'b0;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // =====================================================================
   // serial target: address, pointer, write and read bytes
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_reg   <= ACS_ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         ptr_reg     <= 8'h00;
         rd_mode_reg <= 1'b0;
         acked_reg   <= 1'b0;
         sda_oe_o    <= 1'b0;
         wr_stb_reg  <= 1'b0;
         wr_reg      <= '0;
      end else begin
         wr_stb_reg <= 1'b0;
         if (stop_det) begin
            state_reg <= ACS_ST_IDLE;
            sda_oe_o  <= 1'b0;
         end else if (start_det) begin
            state_reg   <= ACS_ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_o    <= 1'b0;
         end else begin
            case (state_reg)
               ACS_ST_ADDR, ACS_ST_PTR, ACS_ST_WDATA: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     bit_cnt_reg <= 4'h0;
                     if (state_reg == ACS_ST_ADDR) begin
                        if (shift_reg[7:1] == {`ACS_ADDR_UPPER, addr_sel_s}) begin
                           rd_mode_reg <= shift_reg[0];
                           sda_oe_o    <= 1'b1;
                           state_reg   <= ACS_ST_ACK_ADDR;
                        end else begin
                           state_reg <= ACS_ST_IDLE;
                        end
                     end else if (state_reg == ACS_ST_PTR) begin
                        ptr_reg   <= shift_reg;
                        sda_oe_o  <= 1'b1;
                        state_reg <= ACS_ST_ACK_WR;
                     end else begin
                        wr_stb_reg <= 1'b1;
                        wr_reg     <= '{addr: ptr_reg, data: shift_reg};
                        ptr_reg    <= ptr_reg + 8'h01;
                        sda_oe_o   <= 1'b1;
                        state_reg  <= ACS_ST_ACK_WR;
                     end
                  end
               end
               ACS_ST_ACK_ADDR: begin
                  if (scl_fall) begin
                     if (rd_mode_reg) begin
                        shift_reg   <= rd_data;
                        sda_oe_o    <= ~rd_data[7];
                        bit_cnt_reg <= 4'h1;
                        state_reg   <= ACS_ST_RDATA;
                     end else begin
                        sda_oe_o  <= 1'b0;
                        state_reg <= ACS_ST_PTR;
                     end
                  end
               end
               ACS_ST_ACK_WR: begin
                  if (scl_fall) begin
                     sda_oe_o  <= 1'b0;
                     state_reg <= ACS_ST_WDATA;
                  end
               end
               ACS_ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == 4'h8) begin
                        sda_oe_o  <= 1'b0;
                        state_reg <= ACS_ST_RACK;
                     end else begin
                        sda_oe_o    <= ~shift_reg[6];
                        shift_reg   <= {shift_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               ACS_ST_RACK: begin
                  if (scl_rise) begin
                     acked_reg <= ~sda_s;
                     if (!sda_s) begin
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end else if (scl_fall) begin
                     if (acked_reg) begin
                        shift_reg   <= rd_data;
                        sda_oe_o    <= ~rd_data[7];
                        bit_cnt_reg <= 4'h1;
                        state_reg   <= ACS_ST_RDATA;
                     end else begin
                        state_reg <= ACS_ST_IDLE;
                     end
                  end
               end
               default: begin
                  state_reg <= ACS_ST_IDLE;
               end
            endcase
         end
      end
   end

   // =====================================================================
   // read-back mux
   always_comb begin
      case (ptr_reg)
         `ACS_OFS_LINE_PARALLEL_BRIDGE_MODE:   rd_data = line_parallel_bridge_mode_reg;
         `ACS_OFS_DIAG:        rd_data = diag_reg;
         `ACS_OFS_CLOCK:       rd_data = clock_reg;
         `ACS_OFS_SAP:         rd_data = sap_reg;
         `ACS_OFS_CHAN_STATE:  rd_data = chan_state_reg;
         `ACS_OFS_FAULT:       rd_data = {6'h00, parallel_bridge_mode_fault_reg};
         `ACS_OFS_LINE_DETECT: rd_data = {4'h0, line_detect_reg};
         `ACS_OFS_MISC3:       rd_data = misc3_reg;
         `ACS_OFS_ILIM:        rd_data = {4'h0, ilim_flags_reg};
         `ACS_OFS_MISC4:       rd_data = misc4_reg;
         default:              rd_data = 8'h00;
      endcase
   end

   // =====================================================================
   // writable registers
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         line_parallel_bridge_mode_reg   <= `ACS_RST_LINE_PARALLEL_BRIDGE_MODE;
         diag_reg        <= `ACS_RST_DIAG;
         clock_reg       <= `ACS_RST_CLOCK;
         sap_reg         <= `ACS_RST_SAP;
         chan_state_reg  <= `ACS_RST_CHAN_STATE;
         misc3_reg       <= `ACS_RST_MISC3;
         misc4_reg       <= `ACS_RST_MISC4;
         clear_fault_reg <= 1'b0;
      end else begin
         clear_fault_reg <= wr_stb_reg && wr_reg.addr == `ACS_OFS_MISC3
                            && wr_reg.data[`ACS_BIT_CLEAR_FAULT];
         if (wr_stb_reg) begin
            case (wr_reg.addr)
               `ACS_OFS_LINE_PARALLEL_BRIDGE_MODE:  line_parallel_bridge_mode_reg  <= wr_reg.data;
               `ACS_OFS_DIAG:       diag_reg       <= wr_reg.data;
               `ACS_OFS_CLOCK:      clock_reg      <= wr_reg.data;
               `ACS_OFS_SAP:        sap_reg        <= wr_reg.data;
               `ACS_OFS_CHAN_STATE: chan_state_reg <= wr_reg.data;
               `ACS_OFS_MISC3:      misc3_reg      <= wr_reg.data & `ACS_MISC3_STORE;
               `ACS_OFS_MISC4:      misc4_reg      <= wr_reg.data;
               default: begin
               end
            endcase
         end
      end
   end

   // =====================================================================
   // status flags and faults, set wins over clear
   assign all_standby = (chan_state_reg == {4{`ACS_STATE_STANDBY}});

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ilim_flags_reg  <= 4'h0;
         parallel_bridge_mode_fault_reg  <= 2'h0;
         line_detect_reg <= 4'h0;
      end else begin
         // status register has no write path
         ilim_flags_reg <= (clear_fault_reg ? 4'h0 : ilim_flags_reg)
                           | current_limit_i;
         parallel_bridge_mode_fault_reg <= (clear_fault_reg ? 2'h0 : parallel_bridge_mode_fault_reg)
            | {parallel_bridge_mode_o[1] && chan_state_reg[5:4] != chan_state_reg[7:6],
               parallel_bridge_mode_o[0] && chan_state_reg[1:0] != chan_state_reg[3:2]};
         if (diag_valid_i && line_parallel_bridge_mode_reg[diag_chan_i]) begin
            line_detect_reg[diag_chan_i] <= diag_ohms_i >= `ACS_LINE_OHMS_MIN
                                            && diag_ohms_i <= `ACS_LINE_OHMS_MAX;
         end
      end
   end

   // =====================================================================
   // outputs to the audio path
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         warn_n_o               <= 1'b1;
         parallel_bridge_mode_o <= 2'h0;
         diag_run_o             <= 4'h0;
         sw_ratio_o             <= `ACS_SW_RATIO_3;
         sap_cfg_o              <= '0;
      end else begin
         warn_n_o <= ~((|ilim_flags_reg) & ~misc3_reg[`ACS_BIT_ILIM_MASK]);
         if (all_standby) begin
            parallel_bridge_mode_o <= {line_parallel_bridge_mode_reg[`ACS_BIT_PARALLEL_BRIDGE_MODE_REQ34],
                                       line_parallel_bridge_mode_reg[`ACS_BIT_PARALLEL_BRIDGE_MODE_REQ12]};
         end
         diag_run_o <= diag_reg[3:0]
            | {{2{parallel_bridge_mode_o[1] & |diag_reg[3:2]}},
               {2{parallel_bridge_mode_o[0] & |diag_reg[1:0]}}};
         case (clock_reg[2:0])
            3'h0:    sw_ratio_o <= `ACS_SW_RATIO_0;
            3'h1:    sw_ratio_o <= `ACS_SW_RATIO_1;
            3'h2:    sw_ratio_o <= `ACS_SW_RATIO_2;
            3'h4:    sw_ratio_o <= `ACS_SW_RATIO_4;
            default: sw_ratio_o <= `ACS_SW_RATIO_3;
         endcase
         sap_cfg_o.format <= acs_fmt_t'(sap_reg[7:6]);
         sap_cfg_o.tdm_cfg <= (sap_reg[7:6] == 2'h3) ? sap_reg[5:3] : 3'h0;
         sap_cfg_o.rate <= (clock_reg[5:4] == 2'h3) ? `ACS_RATE_48K : clock_reg[5:4];
         case (sap_reg[2:0])
            3'h0:    sap_cfg_o.word_bits <= `ACS_WORD_0;
            3'h1:    sap_cfg_o.word_bits <= `ACS_WORD_1;
            3'h2:    sap_cfg_o.word_bits <= `ACS_WORD_2;
            3'h4:    sap_cfg_o.word_bits <= `ACS_WORD_4;
            default: sap_cfg_o.word_bits <= `ACS_WORD_3;
         endcase
      end
   end

   assign highpass_corner_select_o = misc4_reg[2:0];
   assign chan_state_o             = chan_state_reg;
   assign line_driver_o            = line_parallel_bridge_mode_reg[3:0];
   assign parallel_bridge_mode_flip_o              = misc3_reg[`ACS_BIT_PARALLEL_BRIDGE_MODE_FLIP];

   // =====================================================================
   // assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   flag_set_a: assert property ((|current_limit_i) |=> ((ilim_flags_reg & $past(current_limit_i))
      == $past(current_limit_i))) else $error("current-limit flag not set");
   ro_write_a: assert property ((wr_stb_reg && wr_reg.addr == `ACS_OFS_ILIM && !clear_fault_reg
      && current_limit_i == 4'h0) |=> $stable(ilim_flags_reg))
      else $error("status changed by write");
   hp_reset_a: assert property ($fell(reset_i) |-> misc4_reg == 8'h40)
      else $error("high-pass reset value wrong");
   hp_write_a: assert property ((wr_stb_reg && wr_reg.addr == `ACS_OFS_MISC4) |=>
      (misc4_reg == $past(wr_reg.data) && highpass_corner_select_o == $past(wr_reg.data[2:0])))
      else $error("high-pass write lost");
   warn_mask_a: assert property (##1 warn_n_o ==
      !$past((|ilim_flags_reg) && !misc3_reg[`ACS_BIT_ILIM_MASK]))
      else $error("warning pin wrong");
   parallel_bridge_mode_standby_a: assert property (!$stable(parallel_bridge_mode_o) |-> $past(all_standby))
      else $error("bridge mode changed outside standby");
   parallel_bridge_mode_fault_a: assert property ((parallel_bridge_mode_o[0]
      && chan_state_reg[1:0] != chan_state_reg[3:2]) |=> parallel_bridge_mode_fault_reg[0] [*2])
      else $error("pair mismatch not flagged");
   tdm_only_a: assert property ((sap_cfg_o.format != ACS_FMT_TDM) |-> sap_cfg_o.tdm_cfg == 3'h0)
      else $error("tdm bits active outside tdm");
   diag_pair_a: assert property ((parallel_bridge_mode_o[0] && diag_reg[0]) |=>
      diag_run_o[1:0] == 2'h3) else $error("pair diagnostic incomplete");

   rd_byte_c: cover property (state_reg == ACS_ST_RACK && scl_rise && !sda_s);
   hp_write_c: cover property (wr_stb_reg && wr_reg.addr == `ACS_OFS_MISC4);
   parallel_bridge_mode_on_c: cover property ($rose(parallel_bridge_mode_o[0]));
   flag_clr_c: cover property (clear_fault_reg && |ilim_flags_reg);

endmodule

/* verification/acs_host_model.sv */
`timescale 1ns/1ps
`include "acs_cfg.svh"

// ==========
// two-wire bus master, bus clock 8 system clocks (200 ns)
module acs_host_model (
   input  wire logic       clk_sys_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            sda_oe_o,
   output logic            rd_stb_o,
   output logic [7:0]      rd_o,
   output logic            acked_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
      rd_stb_o = 1'b0;
      rd_o = 8'h00;
      acked_o = 1'b1;
   end

   // quarter bus period, keeps the bus clock at 200 ns
   task q;
      repeat (2) @(negedge clk_sys_i);
   endtask

   // host alone drives the bus clock
   task bit_x(input logic b, output logic r);
      sda_oe_o = ~b;
      q;
      scl_o = 1'b1;
      q;
      r = sda_i;
      q;
      scl_o = 1'b0;
      q;
   endtask

   task byte_w(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      acked_o = acked_o & ~r;
   endtask

   task start;
      sda_oe_o = 1'b0;
      q;
      scl_o = 1'b1;
      q;
      sda_oe_o = 1'b1;
      q;
      scl_o = 1'b0;
      q;
   endtask

   task stop;
      sda_oe_o = 1'b1;
      q;
      scl_o = 1'b1;
      q;
      sda_oe_o = 1'b0;
      q;
   endtask

   // each device is reached at its own address
   task wr(input logic [1:0] s, input logic [7:0] a, input logic [7:0] d);
      acked_o = 1'b1;
      start;
      byte_w({`ACS_ADDR_UPPER, s, 1'b0});
      byte_w(a);
      byte_w(d);
      stop;
   endtask

   task rd(input logic [1:0] s, input logic [7:0] a);
      logic r;
      acked_o = 1'b1;
      start;
      byte_w({`ACS_ADDR_UPPER, s, 1'b0});
      byte_w(a);
      start;
      byte_w({`ACS_ADDR_UPPER, s, 1'b1});
      for (int i = 7; i >= 0; i--) bit_x(1'b1, rd_o[i]);
      bit_x(1'b1, r);
      stop;
      rd_stb_o = 1'b1;
      @(negedge clk_sys_i);
      rd_stb_o = 1'b0;
   endtask
endmodule

/* verification/acs_regs_bench.sv */
`timescale 1ns/1ps

// ==========
// bench for the control and status registers
module acs_regs_bench
   import acs_pkg::*;
;
   logic clk, reset, scl, host_oe, dut_oe, sda_do, warn_n, flip, dv, rd_stb, acked;
   logic [1:0] sel, pb, dch, j;
   logic [2:0] hp;
   logic [3:0] cl, ld, drun;
   logic [5:0] sw;
   logic [7:0] cs, rd_d, k;
   logic [12:0] dohm;
   acs_sap_cfg_t serial_audio_port;
   logic [7:0] exp_q[$];
   logic [7:0] swt[5] = '{8'h08, 8'h0A, 8'h26, 8'h2C, 8'h30};
   logic [7:0] wdt[5] = '{8'h10, 8'h12, 8'h14, 8'h18, 8'h20};
   logic [12:0] ohm[4] = '{13'h258, 13'h257, 13'h125C, 13'h125D};
   int fail_count = 0;
   int checks = 0;
   // pulled-up data line
   wire sda = (dut_oe ? sda_do : 1'b1) & ~host_oe;

   always #12.5 clk = ~clk;

   acs_regs acs_regs_i (.clk_sys_i(clk), .reset_i(reset), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_do), .sda_oe_o(dut_oe), .addr_sel_i(sel), .current_limit_i(cl),
      .diag_valid_i(dv), .diag_chan_i(dch), .diag_ohms_i(dohm), .warn_n_o(warn_n),
      .highpass_corner_select_o(hp), .sw_ratio_o(sw), .sap_cfg_o(serial_audio_port),
      .chan_state_o(cs), .line_driver_o(ld), .parallel_bridge_mode_o(pb),
      .parallel_bridge_mode_flip_o(flip), .diag_run_o(drun));

   acs_host_model acs_host_model_i (.clk_sys_i(clk), .sda_i(sda), .scl_o(scl),
      .sda_oe_o(host_oe), .rd_stb_o(rd_stb), .rd_o(rd_d), .acked_o(acked));

   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   task w(input logic [7:0] a, input logic [7:0] d);
      acs_host_model_i.wr(sel, a, d);
   endtask

   task r(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acs_host_model_i.rd(sel, a);
   endtask

   task results;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ==========
   // read watcher
   always @(posedge clk) begin
      if (rd_stb === 1'b1) chk("read", exp_q.pop_front(), rd_d);
   end

   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      results;
   end

   // ==========
   // main sequence
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      cl = 4'h0;
      dv = 1'b0;
      dch = 2'h0;
      dohm = 13'h0;
      void'($urandom(92010));
      sel = 2'($urandom);
      j = 2'($urandom);
      repeat (6) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      repeat (4) @(negedge clk);
      chk("hp", 8'h00, 8'(hp));
      chk("sw", 8'h2C, 8'(sw));
      chk("warn", 8'h01, 8'(warn_n));
      chk("state", 8'hFF, cs);
      r(8'h26, 8'h40);
      r(8'h25, 8'h00);
      for (int i = 0; i < 8; i++) begin
         k = {5'($urandom), 3'(i)};
         w(8'h26, k);
         chk("hp", 8'(i), 8'(hp));
         r(8'h26, k);
      end
      $display("test highpass done");
      for (int i = 0; i < 5; i++) begin
         w(8'h02, {2'h0, 2'(i % 3), 1'b0, 3'(i)});
         chk("sw", swt[i], 8'(sw));
         chk("rate", 8'(i % 3), 8'(serial_audio_port.rate));
         w(8'h03, {2'(i), 3'(i + 1), 3'(i)});
         chk("fmt", 8'(i % 4), 8'(serial_audio_port.format));
         chk("tdm", (i == 3) ? 8'h04 : 8'h00, 8'(serial_audio_port.tdm_cfg));
         chk("word", wdt[i], 8'(serial_audio_port.word_bits));
      end
      $display("test modes done");
      @(negedge clk) cl = 4'h1 << j;
      @(negedge clk) cl = 4'h0;
      repeat (2) @(negedge clk);
      chk("warn", 8'h00, 8'(warn_n));
      r(8'h25, 8'h01 << j);
      w(8'h25, 8'hFF);
      r(8'h25, 8'h01 << j);
      w(8'h21, 8'h60);
      chk("warn", 8'h01, 8'(warn_n));
      chk("flip", 8'h01, 8'(flip));
      w(8'h21, 8'hE0);
      r(8'h25, 8'h00);
      r(8'h21, 8'h60);
      w(8'h21, 8'h00);
      $display("test current limit done");
      w(8'h04, 8'hF0);
      w(8'h00, 8'h10);
      chk("pb", 8'h00, 8'(pb));
      w(8'h04, 8'hFF);
      chk("pb", 8'h01, 8'(pb));
      w(8'h01, 8'h01);
      chk("run", 8'h03, 8'(drun));
      w(8'h04, 8'hFC);
      r(8'h05, 8'h01);
      w(8'h04, 8'hFF);
      w(8'h21, 8'h80);
      r(8'h05, 8'h00);
      w(8'h01, 8'h00);
      w(8'h00, 8'h0F);
      chk("line", 8'h0F, 8'(ld));
      $display("test bridge done");
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         dv = 1'b1;
         dch = j;
         dohm = ohm[i];
         @(negedge clk) dv = 1'b0;
         r(8'h06, (i % 2 == 0) ? 8'h01 << j : 8'h00);
      end
      r(8'h05, 8'h00);
      w(8'h04, 8'h00);
      chk("state", 8'h00, cs);
      $display("test line detect done");
      acs_host_model_i.wr(sel ^ 2'h1, 8'h26, 8'h00);
      chk("ack", 8'h00, 8'(acked));
      r(8'h26, k);
      $display("test address done");
      results;
   end
endmodule
